// *** core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Stands in for the decoder; each call holds one op or event for exactly one cycle
module core_model (
	input wire logic sys_clk,
	output var flag_pkg::alu_op_t alu_op,
	output var flag_pkg::core_evt_t core_evt
);
	initial begin
		alu_op = '0;
		core_evt = '0;
	end
	task automatic run_op(input flag_pkg::op_kind_t k, input logic [7:0] a, input logic [7:0] b);
		@(posedge sys_clk);
		alu_op <= '{kind: k, a: a, b: b};
		@(posedge sys_clk);
		alu_op <= '0;
	endtask : run_op
	task automatic pulse(input flag_pkg::core_evt_t e);
		@(posedge sys_clk);
		core_evt <= e;
		@(posedge sys_clk);
		core_evt <= '0;
	endtask : pulse
endmodule : core_model
`default_nettype wire

// *** flag_pkg.sv ***
package flag_pkg;

	// Bit positions inside condition_flags
	localparam int unsigned FB_SPILL = 0;
	localparam int unsigned FB_NIBBLE = 1;
	localparam int unsigned FB_NULL = 2;
	localparam int unsigned FB_RANGE = 3;
	localparam int unsigned FB_SLEEP = 4;
	localparam int unsigned FB_WDOG = 5;
	localparam int unsigned FB_CHAIN = 6;
	localparam int unsigned FB_CMP = 7;

	// Bits that instructions and data writes may change
	localparam logic [7:0] FLAGS_WR_MASK = 8'hcf;
	localparam logic [7:0] FLAGS_RST = 8'h00;

	// Register byte offsets on the AXI4-Lite slave
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFF_FLAGS = 4'h0;
	localparam logic [3:0] OFF_EVT = 4'h4;
	localparam logic [3:0] OFF_MASK = 4'h8;

	// Event status bits
	localparam int unsigned EV_WDOG = 0;
	localparam int unsigned EV_SLEEP = 1;
	localparam int unsigned EV_NULL = 2;
	localparam int unsigned EV_W = 3;
	localparam logic [2:0] EVT_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		op_none,
		op_add,
		op_add_carry,
		op_minus,
		op_minus_borrow,
		op_rot_left_c,
		op_rot_right_c,
		op_and,
		op_or,
		op_xor
	} op_kind_t;

	// One ALU operation presented at write-back
	typedef struct packed {
		op_kind_t kind;
		logic [7:0] a;
		logic [7:0] b;
	} alu_op_t;

	// System events and data writes from the core
	typedef struct packed {
		logic flag_wr;
		logic [7:0] flag_wdata;
		logic wdog_expire;
		logic kick;
		logic sleep;
	} core_evt_t;

endpackage : flag_pkg

// *** status_flag_logic.sv ***
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: Carry on add, no-borrow on subtract
// RQ2: Rotate through carry uses and loads carry
// RQ3: Nibble carry or nibble no-borrow flag
// RQ4: Zero flag tracks zero result
// RQ5: Overflow is carry-in xor carry-out of msb
// RQ6: Compare flag is overflow xor result msb
// RQ7: Subtract copies zero into chained flag
// RQ8: Borrow subtract ANDs chained with zero
// RQ9: Other instructions keep chained flag
// RQ10: Watchdog and sleep bits not writable
// RQ11: Watchdog bit cleared by kick, sleep, reset
// RQ12: Sleep bit set by sleep, cleared by kick
// RQ13: Flags never saved automatically
// RQ14: Flags update with write-back, else hold
module status_flag_logic (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire flag_pkg::alu_op_t alu_op,
	input wire flag_pkg::core_evt_t core_evt,
	output logic [7:0] condition_flags,
	output logic [7:0] alu_result,
	output logic irq,
	input wire logic awvalid,
	output logic awready,
	input wire logic [flag_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [flag_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	logic [7:0] flags_r, flags_nxt, res_r, res_nxt;
	logic [2:0] evt_r, evt_nxt, mask_r, mask_nxt, evt_set;
	logic irq_r, irq_nxt;
	logic awready_r, awready_nxt, bvalid_r, bvalid_nxt;
	logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [8:0] s9;
	logic [4:0] n5;
	logic [7:0] bb, wd;
	logic cin, is_arith, zero, ovf, wr_fire, rd_fire;

	// Shared adder: subtract is a + ~b + 1, borrow forms feed the old carry
	always_comb begin
		is_arith = (alu_op.kind == flag_pkg::op_add) || (alu_op.kind == flag_pkg::op_add_carry)
			|| (alu_op.kind == flag_pkg::op_minus) || (alu_op.kind == flag_pkg::op_minus_borrow);
		bb = alu_op.b;
		cin = 1'b0;
		case (alu_op.kind)
			flag_pkg::op_add_carry: begin
				cin = flags_r[flag_pkg::FB_SPILL];
			end
			flag_pkg::op_minus: begin
				bb = ~alu_op.b;
				cin = 1'b1;
			end
			flag_pkg::op_minus_borrow: begin
				bb = ~alu_op.b;
				cin = flags_r[flag_pkg::FB_SPILL];
			end
			default: begin
				cin = 1'b0;
			end
		endcase
		s9 = {1'b0, alu_op.a} + {1'b0, bb} + {8'h00, cin};
		n5 = {1'b0, alu_op.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		ovf = (alu_op.a[7] ^ bb[7] ^ s9[7]) ^ s9[8]; // RQ5
	end

	always_comb begin
		flags_nxt = flags_r;
		res_nxt = res_r;
		zero = 1'b0;
		wd = wdata[7:0];
		if (wr_fire && awaddr == flag_pkg::OFF_FLAGS && wstrb[0]) begin
			flags_nxt = (flags_r & ~flag_pkg::FLAGS_WR_MASK) | (wd & flag_pkg::FLAGS_WR_MASK); // RQ10
		end
		if (core_evt.flag_wr) begin
			flags_nxt = (flags_r & ~flag_pkg::FLAGS_WR_MASK)
				| (core_evt.flag_wdata & flag_pkg::FLAGS_WR_MASK); // RQ10
		end
		// An ALU write-back outranks a data write to the flags in the same cycle
		case (alu_op.kind)
			flag_pkg::op_add, flag_pkg::op_add_carry,
			flag_pkg::op_minus, flag_pkg::op_minus_borrow: begin
				res_nxt = s9[7:0];
				zero = (s9[7:0] == 8'h00);
				flags_nxt[flag_pkg::FB_SPILL] = s9[8]; // RQ1
				flags_nxt[flag_pkg::FB_NIBBLE] = n5[4]; // RQ3
				flags_nxt[flag_pkg::FB_NULL] = zero; // RQ4
				flags_nxt[flag_pkg::FB_RANGE] = ovf; // RQ5
				flags_nxt[flag_pkg::FB_CMP] = ovf ^ s9[7]; // RQ6
				if (alu_op.kind == flag_pkg::op_minus) begin
					flags_nxt[flag_pkg::FB_CHAIN] = zero; // RQ7
				end else if (alu_op.kind == flag_pkg::op_minus_borrow) begin
					flags_nxt[flag_pkg::FB_CHAIN] = flags_r[flag_pkg::FB_CHAIN] & zero; // RQ8
				end
			end
			flag_pkg::op_rot_left_c: begin
				res_nxt = {alu_op.a[6:0], flags_r[flag_pkg::FB_SPILL]}; // RQ2
				flags_nxt[flag_pkg::FB_SPILL] = alu_op.a[7]; // RQ2
			end
			flag_pkg::op_rot_right_c: begin
				res_nxt = {flags_r[flag_pkg::FB_SPILL], alu_op.a[7:1]}; // RQ2
				flags_nxt[flag_pkg::FB_SPILL] = alu_op.a[0]; // RQ2
			end
			flag_pkg::op_and, flag_pkg::op_or, flag_pkg::op_xor: begin
				case (alu_op.kind)
					flag_pkg::op_and: res_nxt = alu_op.a & alu_op.b;
					flag_pkg::op_or: res_nxt = alu_op.a | alu_op.b;
					default: res_nxt = alu_op.a ^ alu_op.b;
				endcase
				zero = (res_nxt == 8'h00);
				flags_nxt[flag_pkg::FB_NULL] = zero; // RQ4 RQ9
			end
			default: begin
				res_nxt = res_r; // RQ14
			end
		endcase
		// Kick and sleep can arrive in the same cycle; sleep is applied last, so it wins
		if (core_evt.kick) begin
			flags_nxt[flag_pkg::FB_WDOG] = 1'b0; // RQ11
			flags_nxt[flag_pkg::FB_SLEEP] = 1'b0; // RQ12
		end
		if (core_evt.sleep) begin
			flags_nxt[flag_pkg::FB_WDOG] = 1'b0; // RQ11
			flags_nxt[flag_pkg::FB_SLEEP] = 1'b1; // RQ12
		end
		// A time-out in the same cycle as a clear must not be lost
		if (core_evt.wdog_expire) begin
			flags_nxt[flag_pkg::FB_WDOG] = 1'b1; // RQ11
		end
	end

	// Flags leave only through condition_flags and the AXI read data; no stack path exists
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			flags_r <= flag_pkg::FLAGS_RST; // RQ11 RQ12
			res_r <= 8'h00;
		end else begin
			flags_r <= flags_nxt; // RQ13 RQ14
			res_r <= res_nxt;
		end
	end

	// Sticky events, write one to clear; a set in the clear cycle wins
	always_comb begin
		evt_set = '0;
		evt_set[flag_pkg::EV_WDOG] = core_evt.wdog_expire;
		evt_set[flag_pkg::EV_SLEEP] = core_evt.sleep;
		evt_set[flag_pkg::EV_NULL] = is_arith && zero;
		evt_nxt = evt_r;
		mask_nxt = mask_r;
		if (wr_fire && wstrb[0] && awaddr == flag_pkg::OFF_EVT) begin
			evt_nxt = evt_r & ~wdata[2:0];
		end
		if (wr_fire && wstrb[0] && awaddr == flag_pkg::OFF_MASK) begin
			mask_nxt = wdata[2:0];
		end
		evt_nxt = evt_nxt | evt_set;
		irq_nxt = |(evt_nxt & mask_nxt);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			evt_r <= flag_pkg::EVT_RST;
			mask_r <= flag_pkg::MASK_RST;
			irq_r <= 1'b0;
		end else begin
			evt_r <= evt_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// AXI4-Lite: address and data are taken together, one write and one read at a time, each channel independent
	assign wr_fire = awready_r && awvalid && wvalid;
	assign rd_fire = arready_r && arvalid;

	always_comb begin
		awready_nxt = awvalid && wvalid && !awready_r && !bvalid_r;
		bvalid_nxt = wr_fire || (bvalid_r && !bready);
		bresp_nxt = bresp_r;
		if (wr_fire) begin
			bresp_nxt = (awaddr == flag_pkg::OFF_FLAGS || awaddr == flag_pkg::OFF_EVT
				|| awaddr == flag_pkg::OFF_MASK) ? flag_pkg::RESP_OKAY : flag_pkg::RESP_SLVERR;
		end
		arready_nxt = arvalid && !arready_r && !rvalid_r;
		rvalid_nxt = rd_fire || (rvalid_r && !rready);
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rd_fire) begin
			rresp_nxt = flag_pkg::RESP_OKAY;
			case (araddr)
				flag_pkg::OFF_FLAGS: rdata_nxt = {24'h000000, flags_r};
				flag_pkg::OFF_EVT: rdata_nxt = {29'h0, evt_r};
				flag_pkg::OFF_MASK: rdata_nxt = {29'h0, mask_r};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = flag_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			awready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= flag_pkg::RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= flag_pkg::RESP_OKAY;
		end else begin
			awready_r <= awready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign condition_flags = flags_r;
	assign alu_result = res_r;
	assign irq = irq_r;
	assign awready = awready_r;
	assign wready = awready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	logic quiet;
	assign quiet = alu_op.kind == flag_pkg::op_none && !core_evt.flag_wr && !core_evt.kick
		&& !core_evt.sleep && !core_evt.wdog_expire && !wr_fire;
	property p_carry;
		alu_op.kind == flag_pkg::op_minus
			|=> flags_r[flag_pkg::FB_SPILL] == ($past(alu_op.a) >= $past(alu_op.b));
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong"); // RQ1

	property p_rot;
		alu_op.kind == flag_pkg::op_rot_left_c
			|=> flags_r[flag_pkg::FB_SPILL] == $past(alu_op.a[7])
			&& res_r[0] == $past(flags_r[flag_pkg::FB_SPILL]);
	endproperty
	a_rot: assert property (p_rot) else $error("rotate carry wrong"); // RQ2

	property p_nib;
		alu_op.kind == flag_pkg::op_minus
			|=> flags_r[flag_pkg::FB_NIBBLE] == ($past(alu_op.a[3:0]) >= $past(alu_op.b[3:0]));
	endproperty
	a_nib: assert property (p_nib) else $error("nibble flag wrong"); // RQ3

	property p_zero;
		alu_op.kind == flag_pkg::op_xor |=> flags_r[flag_pkg::FB_NULL] == (res_r == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RQ4

	property p_ovf;
		alu_op.kind == flag_pkg::op_add |=> flags_r[flag_pkg::FB_RANGE]
			== ($past(alu_op.a[7]) == $past(alu_op.b[7]) && res_r[7] != $past(alu_op.a[7]));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // RQ5

	property p_cmp;
		is_arith |=> flags_r[flag_pkg::FB_CMP] == (flags_r[flag_pkg::FB_RANGE] ^ res_r[7]);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare flag wrong"); // RQ6

	property p_chain_sub;
		alu_op.kind == flag_pkg::op_minus
			|=> flags_r[flag_pkg::FB_CHAIN] == flags_r[flag_pkg::FB_NULL];
	endproperty
	a_chain_sub: assert property (p_chain_sub) else $error("chained flag on subtract"); // RQ7

	property p_chain_sbc;
		alu_op.kind == flag_pkg::op_minus_borrow |=> flags_r[flag_pkg::FB_CHAIN]
			== ($past(flags_r[flag_pkg::FB_CHAIN]) && flags_r[flag_pkg::FB_NULL]);
	endproperty
	a_chain_sbc: assert property (p_chain_sbc) else $error("chained flag on borrow"); // RQ8

	property p_chain_hold;
		(alu_op.kind == flag_pkg::op_add || alu_op.kind == flag_pkg::op_and)
			&& !core_evt.flag_wr && !wr_fire |=> $stable(flags_r[flag_pkg::FB_CHAIN]);
	endproperty
	a_chain_hold: assert property (p_chain_hold) else $error("chained flag moved"); // RQ9

	property p_ro;
		core_evt.flag_wr && !core_evt.kick && !core_evt.sleep && !core_evt.wdog_expire
			|=> $stable(flags_r[5:4]);
	endproperty
	a_ro: assert property (p_ro) else $error("system bits written"); // RQ10

	property p_wdog;
		core_evt.wdog_expire |=> flags_r[flag_pkg::FB_WDOG] && evt_r[flag_pkg::EV_WDOG];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog flag not set"); // RQ11

	property p_sleep;
		core_evt.sleep && !core_evt.wdog_expire
			|=> flags_r[flag_pkg::FB_SLEEP] && !flags_r[flag_pkg::FB_WDOG];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong"); // RQ12

	property p_hold;
		quiet |=> $stable(flags_r) && $stable(res_r);
	endproperty
	a_hold: assert property (p_hold) else $error("flags moved while idle"); // RQ14

	c_sbc_chain: cover property (alu_op.kind == flag_pkg::op_minus_borrow
		##1 flags_r[flag_pkg::FB_CHAIN]);
	c_irq: cover property (core_evt.wdog_expire ##[1:20] irq_r);
	c_sleep_kick: cover property (core_evt.sleep ##[1:20] core_evt.kick);

endmodule : status_flag_logic

`default_nettype wire

// *** status_flag_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module status_flag_logic_tb;
	typedef struct packed {
		flag_pkg::op_kind_t k;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] f;
		logic [7:0] r;
	} row_t;
	// Rows run in order: carry and chained flags flow from one row into the next
	localparam row_t ROWS [13] = '{
		'{flag_pkg::op_add, 8'h80, 8'h80, 8'h8d, 8'h00},
		'{flag_pkg::op_add_carry, 8'h0f, 8'h00, 8'h02, 8'h10},
		'{flag_pkg::op_minus, 8'h05, 8'h05, 8'h47, 8'h00},
		'{flag_pkg::op_minus_borrow, 8'h00, 8'h00, 8'h47, 8'h00},
		'{flag_pkg::op_add, 8'h01, 8'h01, 8'h40, 8'h02},
		'{flag_pkg::op_minus_borrow, 8'h10, 8'h01, 8'h01, 8'h0e},
		'{flag_pkg::op_add, 8'h7f, 8'h01, 8'h0a, 8'h80},
		'{flag_pkg::op_minus, 8'h80, 8'h01, 8'h89, 8'h7f},
		'{flag_pkg::op_rot_left_c, 8'h00, 8'h00, 8'h88, 8'h01},
		'{flag_pkg::op_rot_right_c, 8'h01, 8'h00, 8'h89, 8'h00},
		'{flag_pkg::op_and, 8'hf0, 8'h0f, 8'h8d, 8'h00},
		'{flag_pkg::op_or, 8'h01, 8'h02, 8'h89, 8'h03},
		'{flag_pkg::op_xor, 8'h55, 8'h55, 8'h8d, 8'h00}
	};
	// Event word then expected flags; several pulses land together on purpose
	localparam logic [19:0] EVS [7] = '{
		{1'b1, 8'hff, 3'b000, 8'hcf}, {1'b0, 8'h00, 3'b100, 8'hef},
		{1'b1, 8'h00, 3'b000, 8'h20}, {1'b0, 8'h00, 3'b001, 8'h10},
		{1'b0, 8'h00, 3'b011, 8'h10}, {1'b0, 8'h00, 3'b110, 8'h20},
		{1'b0, 8'h00, 3'b010, 8'h00}
	};
	logic sys_clk, nrst, irq;
	flag_pkg::alu_op_t alu_op;
	flag_pkg::core_evt_t core_evt;
	logic [7:0] condition_flags, alu_result;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, got;
	logic [1:0] bresp, rresp, resp;
	int err_count = 0;
	int total_checks = 0;
	core_model core_model_inst (.sys_clk(sys_clk), .alu_op(alu_op), .core_evt(core_evt));
	status_flag_logic status_flag_logic_inst (.sys_clk(sys_clk), .nrst(nrst), .alu_op(alu_op),
		.core_evt(core_evt), .condition_flags(condition_flags), .alu_result(alu_result),
		.irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check_eq
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	task automatic axi_write(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st);
		@(posedge sys_clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= ad;
		wdata <= d;
		wstrb <= st;
		bready <= 1'b1;
		do @(posedge sys_clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [3:0] ad);
		@(posedge sys_clk);
		arvalid <= 1'b1;
		araddr <= ad;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_read
	// Whole run is about 125 cycles; this span only catches a hung handshake
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		check_eq(32'(condition_flags), 32'(flag_pkg::FLAGS_RST));
		axi_read(flag_pkg::OFF_MASK);
		check_eq(got, 32'(flag_pkg::MASK_RST));
		foreach (ROWS[i]) begin
			core_model_inst.run_op(ROWS[i].k, ROWS[i].a, ROWS[i].b);
			#1;
			check_eq(32'(condition_flags), 32'(ROWS[i].f));
			check_eq(32'(alu_result), 32'(ROWS[i].r));
		end
		repeat (4) @(posedge sys_clk);
		#1;
		check_eq(32'(condition_flags), 32'h8d);
		foreach (EVS[i]) begin
			core_model_inst.pulse(EVS[i][19:8]);
			#1;
			check_eq(32'(condition_flags), 32'(EVS[i][7:0]));
		end
		axi_write(flag_pkg::OFF_FLAGS, 32'hff, 4'hf);
		axi_read(flag_pkg::OFF_FLAGS);
		check_eq(got, 32'hcf);
		axi_write(flag_pkg::OFF_EVT, 32'h7, 4'hf);
		axi_read(flag_pkg::OFF_EVT);
		check_eq(got, 32'h0);
		axi_write(flag_pkg::OFF_MASK, 32'h2, 4'hf);
		core_model_inst.pulse({1'b0, 8'h00, 3'b001});
		#1;
		check_eq(32'(irq), 32'h1);
		core_model_inst.run_op(flag_pkg::op_minus, 8'h00, 8'h00);
		axi_write(flag_pkg::OFF_MASK, 32'h0, 4'h0);
		check_eq(32'(irq), 32'h1);
		axi_write(flag_pkg::OFF_MASK, 32'h0, 4'hf);
		check_eq(32'(irq), 32'h0);
		axi_read(flag_pkg::OFF_EVT);
		check_eq(got, 32'h6);
		axi_write(flag_pkg::OFF_EVT, 32'h2, 4'hf);
		axi_write(flag_pkg::OFF_MASK, 32'h4, 4'hf);
		check_eq(32'(irq), 32'h1);
		axi_write(flag_pkg::OFF_EVT, 32'h4, 4'hf);
		check_eq(32'(irq), 32'h0);
		axi_write(4'hc, 32'h1, 4'hf);
		check_eq(32'(resp), 32'(flag_pkg::RESP_SLVERR));
		axi_read(4'hc);
		check_eq(got, 32'h0);
		check_eq(32'(resp), 32'(flag_pkg::RESP_SLVERR));
		// Reset again mid-run: flags, mask and irq must all return to their reset state
		nrst <= 1'b0;
		@(posedge sys_clk);
		#1;
		check_eq(32'(condition_flags), 32'(flag_pkg::FLAGS_RST));
		check_eq(32'({irq, bvalid, rvalid}), 32'h0);
		@(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		check_eq(32'(condition_flags), 32'(flag_pkg::FLAGS_RST));
		axi_read(flag_pkg::OFF_MASK);
		check_eq(got, 32'(flag_pkg::MASK_RST));
		tally_and_finish();
	end
endmodule : status_flag_logic_tb
`default_nettype wire
